// >>> rtl/evsf_defines.svh
// Purpose: offsets, field positions, reset values for the event status block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: definitions only
`ifndef EVSF_DEFINES_SVH
`define EVSF_DEFINES_SVH
`define EVSF_ADDR_W 8
`define EVSF_OFS_STATUS 8'h0d
`define EVSF_OFS_THR_CTRL 8'h20
`define EVSF_OFS_IRQ_EN 8'h21
`define EVSF_OFS_PROTECT 8'h22
`define EVSF_OFS_IRQ_STAT 8'h23
`define EVSF_OFS_IRQ_CLR 8'h24
`define EVSF_BIT_HIGH 7
`define EVSF_BIT_LOW 6
`define EVSF_BIT_UPD 5
`define EVSF_BIT_CNT 4
`define EVSF_BIT_ALM 3
`define EVSF_BIT_EXT 2
`define EVSF_BIT_POR 1
`define EVSF_BIT_VLOW 0
`define EVSF_CTRL_LOW_CLR 0
`define EVSF_CTRL_HIGH_CLR 1
`define EVSF_PROT_BIT 0
`define EVSF_RST_PROT 1'b0
`define EVSF_RST_STATUS 8'h02
`define EVSF_RST_ZERO 8'h00
`endif

// >>> rtl/evsf_pkg.sv
// Purpose: shared types of the event status block
// Assumes: nothing
// Notes: constants live in evsf_defines.svh
package evsf_pkg;
    typedef logic [7:0] evsf_byte_t;
    typedef logic [7:0] evsf_addr_t;
endpackage

// >>> rtl/evsf_bus_if.sv
// Purpose: decoded register strobes passed from decoder to flag bank
// Assumes: single clock domain
// Notes: none
`timescale 1ns/100ps
interface evsf_bus_if;
    logic wr_status;
    logic wr_ctrl;
    logic wr_en;
    logic wr_prot;
    logic wr_iclr;
    logic [7:0] wdata;
    modport dec (output wr_status, wr_ctrl, wr_en, wr_prot, wr_iclr, wdata);
    modport bank (input wr_status, wr_ctrl, wr_en, wr_prot, wr_iclr, wdata);
endinterface

// >>> rtl/evsf_decode.sv
// Purpose: address decode of register writes
// Assumes: write strobe one cycle long
// Notes: status and threshold clear writes gated by protection
`timescale 1ns/100ps
`include "evsf_defines.svh"
module evsf_decode (
    input wire logic i_wr,
    input wire logic i_protect,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    evsf_bus_if.dec bus
);
    // protectable writes blocked while locked; protect reg itself stays writable
    assign bus.wr_status = i_wr && !i_protect && (i_addr == `EVSF_OFS_STATUS);
    assign bus.wr_ctrl = i_wr && !i_protect && (i_addr == `EVSF_OFS_THR_CTRL);
    assign bus.wr_en = i_wr && (i_addr == `EVSF_OFS_IRQ_EN);
    assign bus.wr_prot = i_wr && (i_addr == `EVSF_OFS_PROTECT);
    assign bus.wr_iclr = i_wr && (i_addr == `EVSF_OFS_IRQ_CLR);
    assign bus.wdata = i_wdata;
endmodule // evsf_decode

// >>> rtl/evsf_status.sv
// Purpose: sticky event status flags with register port and interrupt
// Assumes: event inputs are one-clock pulses from logic on i_mclk
//          events come from logic on the same clock, so they need no synchronisers
// Notes: unmapped and write-only offsets read as zero
//        the lock blocks writes to the status and threshold clear offsets only
//        an event in the same cycle as a clear leaves its flag set
//        interrupt flags mirror the status layout but are cleared on their own
//
// Summary of operation
// - Status flags can only be read or cleared by software, never set by a write.
// - The low temperature flag is set when temperature falls below the low threshold.
// - The low temperature flag stays set until software writes 0 to it.
// - Writing 1 to the low flag clear bit also clears the low temperature flag.
// - The time update flag is set by an update event and held until 0 is written.
// - The countdown flag is set by a countdown timer event.
// - Writes to protectable registers are blocked while protection is active.
`timescale 1ns/100ps
`include "evsf_defines.svh"
module evsf_status (
    input wire logic i_mclk,
    input wire logic i_rst,
    // register port
    input wire evsf_pkg::evsf_addr_t i_addr,
    input wire evsf_pkg::evsf_byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    // events from the comparators and the timing units
    input wire logic i_temp_above_high,
    input wire logic i_temp_below_low,
    input wire logic i_update_evt,
    input wire logic i_countdown_evt,
    input wire logic i_alarm_evt,
    input wire logic i_ext_evt,
    input wire logic i_power_on_evt,
    input wire logic i_voltage_low_evt,
    // read data and interrupt line
    output evsf_pkg::evsf_byte_t o_rdata,
    output logic o_irq
);
    import evsf_pkg::*;

    // decoded write strobes, shared with the address decoder
    evsf_bus_if bus ();

    // sticky event flags as software reads them at the status offset
    evsf_byte_t status;
    evsf_byte_t next_status;

    // interrupt flags, their enable mask and the write lock
    evsf_byte_t irq_stat;
    evsf_byte_t next_irq_stat;
    evsf_byte_t irq_en;
    evsf_byte_t next_irq_en;
    logic protect;
    logic next_protect;

    // read port, registered so data stand only in the cycle after the strobe
    evsf_byte_t rdata;
    evsf_byte_t next_rdata;

    // interrupt line, registered so the pin never glitches on decode
    logic irq;
    logic next_irq;

    // per-cycle vectors in status bit order
    evsf_byte_t set_vec; // events of this cycle
    evsf_byte_t status_keep; // zero where software clears a status flag
    evsf_byte_t irq_keep; // zero where software clears an interrupt flag

    // one sticky flag: an event sets it, otherwise it is kept or dropped;
    // the event wins over a clear in the same cycle, so a crossing that
    // lands while software clears the flag is never lost
    function automatic logic sticky_next(input logic cur, input logic keep,
        input logic set);
        return set | (cur & keep);
    endfunction

    // address decode and write lock gating
    evsf_decode u_decode (
        .i_wr(i_wr),
        .i_protect(protect),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .bus(bus)
    );

    // event vector in status bit order; a level input simply sets its
    // flag again every cycle, so pulses and levels both work
    always_comb begin
        set_vec = 8'h00;
        set_vec[`EVSF_BIT_HIGH] = i_temp_above_high;
        set_vec[`EVSF_BIT_LOW] = i_temp_below_low;
        set_vec[`EVSF_BIT_UPD] = i_update_evt;
        set_vec[`EVSF_BIT_CNT] = i_countdown_evt;
        set_vec[`EVSF_BIT_ALM] = i_alarm_evt;
        set_vec[`EVSF_BIT_EXT] = i_ext_evt;
        set_vec[`EVSF_BIT_POR] = i_power_on_evt;
        set_vec[`EVSF_BIT_VLOW] = i_voltage_low_evt;
    end

    // status keep mask: a status write keeps only the bits written as 1,
    // so software can clear a flag but never raise one
    always_comb begin
        status_keep = 8'hff;
        if (bus.wr_status) begin
            status_keep = bus.wdata;
        end
        // threshold clear bits drop their own flag and leave the rest
        if (bus.wr_ctrl && bus.wdata[`EVSF_CTRL_LOW_CLR]) begin
            status_keep[`EVSF_BIT_LOW] = 1'b0;
        end
        if (bus.wr_ctrl && bus.wdata[`EVSF_CTRL_HIGH_CLR]) begin
            status_keep[`EVSF_BIT_HIGH] = 1'b0;
        end
    end

    // interrupt keep mask: the clear register is write-one-to-clear and
    // leaves the status flags alone, so polling and interrupts stay apart
    always_comb begin
        irq_keep = 8'hff;
        if (bus.wr_iclr) begin
            irq_keep = ~bus.wdata;
        end
    end

    // next value of every flag of both banks, one bit at a time; each bit
    // is the same sticky cell, so the set-wins order holds for all of them
    // and a flag can only stay at 1 or fall on a software clear
    for (genvar b = 0; b < 8; b++) begin : g_flag
        assign next_status[b] = sticky_next(status[b], status_keep[b], set_vec[b]);
        assign next_irq_stat[b] = sticky_next(irq_stat[b], irq_keep[b], set_vec[b]);
    end

    // enable mask and write lock; the lock register itself stays writable,
    // otherwise a locked block could never be opened again
    always_comb begin
        next_irq_en = irq_en;
        if (bus.wr_en) begin
            next_irq_en = bus.wdata;
        end
        next_protect = protect;
        if (bus.wr_prot) begin
            next_protect = bus.wdata[`EVSF_PROT_BIT];
        end
    end

    // interrupt level from the next flag and mask values, so the pin rises
    // on the same edge as the flag that causes it
    always_comb begin
        next_irq = |(next_irq_stat & next_irq_en);
    end

    // read data for the strobe of this cycle, zero otherwise; write-only
    // and unmapped offsets read as zero, so the port idles at zero
    always_comb begin
        next_rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                `EVSF_OFS_STATUS: next_rdata = status;
                `EVSF_OFS_IRQ_EN: next_rdata = irq_en;
                `EVSF_OFS_PROTECT: next_rdata = {7'h00, protect};
                `EVSF_OFS_IRQ_STAT: next_rdata = irq_stat;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // status flags; after reset only the power-on flag stands, the event
    // flag starts clear since its pin level is not known yet
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            status <= `EVSF_RST_STATUS;
        end else begin
            status <= next_status;
        end
    end

    // interrupt flags and enable mask, all clear after reset
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            irq_stat <= `EVSF_RST_ZERO;
            irq_en <= `EVSF_RST_ZERO;
        end else begin
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
        end
    end

    // write lock, open after reset
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            protect <= `EVSF_RST_PROT;
        end else begin
            protect <= next_protect;
        end
    end

    // read data register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata <= `EVSF_RST_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // interrupt line register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // outputs come straight from their flip-flops
    assign o_rdata = rdata;
    assign o_irq = irq;
endmodule // evsf_status

// >>> tb/evsf_status_monitor.sv
// Purpose: port checks of the event status block
// Assumes: one-cycle strobes, read data in the cycle after the read
// Notes: bound to evsf_status
`timescale 1ns/100ps
`include "evsf_defines.svh"
module evsf_status_monitor (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire evsf_pkg::evsf_addr_t i_addr,
    input wire evsf_pkg::evsf_byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_temp_above_high,
    input wire logic i_temp_below_low,
    input wire logic i_update_evt,
    input wire logic i_countdown_evt,
    input wire evsf_pkg::evsf_byte_t o_rdata
);
    import evsf_pkg::*;
    logic rs;
    logic q;
    logic ws;
    logic locked;
    // status read strobe, absence of the upper events, unlocked status write
    assign rs = i_rd && i_addr == `EVSF_OFS_STATUS;
    assign q = !(i_temp_above_high | i_temp_below_low | i_update_evt | i_countdown_evt);
    assign ws = i_wr && i_addr == `EVSF_OFS_STATUS && q && !locked;
    // lock as last written, so a blocked write is not judged as a clear
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            locked <= `EVSF_RST_PROT;
        end else if (i_wr && i_addr == `EVSF_OFS_PROTECT) begin
            locked <= i_wdata[`EVSF_PROT_BIT];
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    chk_high_set: assert property (i_temp_above_high ##1 !i_wr ##1 rs |=> o_rdata[7])
        else $error("high flag not set");
    chk_low_set: assert property (i_temp_below_low ##1 !i_wr ##1 rs |=> o_rdata[6])
        else $error("low flag not set");
    chk_update_set: assert property (i_update_evt ##1 !i_wr ##1 rs |=> o_rdata[5])
        else $error("update flag not set");
    chk_count_set: assert property (i_countdown_evt ##1 !i_wr ##1 rs |=> o_rdata[4])
        else $error("countdown flag not set");
    chk_write_noset: assert property (ws ##1 (q && !i_wr) ##1 (rs && q) |=>
        (o_rdata & ~$past(i_wdata, 3) & 8'hf0) == 8'h00)
        else $error("status write set a flag");
    chk_unmapped_zero: assert property (i_rd && i_addr == 8'h40 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_wonly_zero: assert property (i_rd && (i_addr == `EVSF_OFS_THR_CTRL ||
        i_addr == `EVSF_OFS_IRQ_CLR) |=> o_rdata == 8'h00)
        else $error("write-only read not zero");
endmodule // evsf_status_monitor
bind evsf_status evsf_status_monitor i_mon (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .i_temp_above_high, .i_temp_below_low, .i_update_evt, .i_countdown_evt, .o_rdata);

// >>> tb/evsf_status_test.sv
// Purpose: self-checking bench of the event status block
// Assumes: xorshift stimulus from a fixed seed
// Notes: events form one byte in status bit order
`timescale 1ns/100ps
`include "evsf_defines.svh"
module evsf_status_test;
    import evsf_pkg::*;
    logic i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, irq;
    evsf_byte_t a = 8'h00, wd = 8'h00, ev = 8'h00, st, en, d, rdata;
    int err_count = 0, checks_done = 0;
    logic [31:0] seed = 32'hb528;
    evsf_status i_dut (.i_mclk, .i_rst, .i_addr(a), .i_wdata(wd), .i_wr, .i_rd,
        .i_temp_above_high(ev[7]), .i_temp_below_low(ev[6]), .i_update_evt(ev[5]),
        .i_countdown_evt(ev[4]), .i_alarm_evt(ev[3]), .i_ext_evt(ev[2]),
        .i_power_on_evt(ev[1]), .i_voltage_low_evt(ev[0]), .o_rdata(rdata), .o_irq(irq));
    // 125 MHz clock
    always #4 i_mclk = ~i_mclk;
    function automatic evsf_byte_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic cmp(evsf_byte_t g, evsf_byte_t e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t %h %h", $time, g, e);
        end
    endtask
    // one bus cycle, then strobes drop
    task automatic bus(logic w, evsf_addr_t x, evsf_byte_t v, evsf_byte_t m);
        @(posedge i_mclk);
        a <= x;
        wd <= v;
        ev <= m;
        i_wr <= w;
        i_rd <= !w && m == 8'h00;
        @(posedge i_mclk);
        {i_wr, i_rd, ev} <= 10'h000;
        #1;
    endtask
    task automatic rd(evsf_addr_t x, evsf_byte_t e);
        bus(1'b0, x, 8'h00, 8'h00);
        cmp(rdata, e);
    endtask
    task automatic final_report();
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(`EVSF_OFS_STATUS, `EVSF_RST_STATUS);
        rd(`EVSF_OFS_IRQ_EN, 8'h00);
        bus(1'b1, `EVSF_OFS_STATUS, 8'hff, 8'h00);
        rd(`EVSF_OFS_STATUS, `EVSF_RST_STATUS);
        bus(1'b1, `EVSF_OFS_STATUS, 8'h00, 8'h00);
        rd(`EVSF_OFS_STATUS, 8'h00);
        for (int k = 0; k < 8; k++) begin
            en = rnd();
            bus(1'b1, `EVSF_OFS_IRQ_EN, en, 8'h00);
            bus(1'b0, 8'h00, 8'h00, 8'h01 << k);
            st = 8'h01 << k;
            cmp({7'h00, irq}, {7'h00, en[k]});
            rd(`EVSF_OFS_STATUS, st);
            rd(`EVSF_OFS_IRQ_STAT, st);
            bus(1'b1, `EVSF_OFS_IRQ_CLR, 8'hff, 8'h00);
            cmp({7'h00, irq}, 8'h00);
            d = rnd() | st;
            bus(1'b1, `EVSF_OFS_STATUS, d, 8'h00);
            rd(`EVSF_OFS_STATUS, st & d);
            bus(1'b1, `EVSF_OFS_STATUS, ~st, 8'h00);
            rd(`EVSF_OFS_STATUS, 8'h00);
        end
        bus(1'b0, 8'h00, 8'h00, 8'hc0);
        bus(1'b1, `EVSF_OFS_THR_CTRL, 8'h01, 8'h00);
        rd(`EVSF_OFS_STATUS, 8'h80);
        bus(1'b1, `EVSF_OFS_THR_CTRL, 8'h02, 8'h00);
        rd(`EVSF_OFS_STATUS, 8'h00);
        // corner: events land in the same cycle as both clears, events win
        bus(1'b1, `EVSF_OFS_THR_CTRL, 8'h03, 8'hd0);
        rd(`EVSF_OFS_STATUS, 8'hd0);
        bus(1'b1, `EVSF_OFS_STATUS, 8'h00, 8'h10);
        rd(`EVSF_OFS_STATUS, 8'h10);
        bus(1'b1, `EVSF_OFS_STATUS, 8'h00, 8'h00);
        bus(1'b1, `EVSF_OFS_PROTECT, 8'h01, 8'h40);
        bus(1'b1, `EVSF_OFS_STATUS, 8'h00, 8'h00);
        bus(1'b1, `EVSF_OFS_THR_CTRL, 8'h01, 8'h00);
        rd(`EVSF_OFS_STATUS, 8'h40);
        bus(1'b1, `EVSF_OFS_PROTECT, 8'h00, 8'h00);
        bus(1'b1, `EVSF_OFS_STATUS, 8'h00, 8'h00);
        rd(`EVSF_OFS_STATUS, 8'h00);
        rd(8'h40, 8'h00);
        rd(`EVSF_OFS_THR_CTRL, 8'h00);
        // reset in mid-run restores the power-on flag and drops the interrupt
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(`EVSF_OFS_STATUS, `EVSF_RST_STATUS);
        cmp({7'h00, irq}, 8'h00);
        final_report();
    end
endmodule // evsf_status_test
